// File: dimp_ctrl.sv
`timescale 1ns/1ps
// controller end: power-up sequence, mode loads, leveling exit
module dimp_ctrl
  import dimp_pkg::*;
#(
  parameter int RESET_HOLD = RESET_HOLD_CYC,
  parameter int CKE_WAIT = CKE_WAIT_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  dimp_if.ctrl lnk,
  input wire logic i_start,
  input wire logic i_power_ok,
  input wire logic [15:0] i_mode_zero,
  input wire logic [15:0] i_mode_one,
  input wire logic [15:0] i_mode_two,
  input wire logic [15:0] i_mode_three,
  input wire logic i_lvl_exit,
  input wire logic i_volt_change,
  input wire logic i_banks_idle,
  output logic o_busy,
  output logic o_ready,
  output logic o_lvl_sample
);
  import dimp_pkg::*;
  // refuse a divider too small to give the link clock two halves, and empty waits
  if (LINK_DIV < 2 || RESET_HOLD < 1 || CKE_WAIT < 1) begin : g_bad_param
    $error("bad parameters");
  end
  // sequencer states, power-up through leveling exit and supply switch
  typedef enum {
    S_IDLE, S_RST_HOLD, S_CKE_SETUP, S_CKE_WAIT, S_PRE_CKE, S_XPR, S_LOAD,
    S_LOAD_GAP, S_CALIB, S_DONE, S_LVL_WAIT, S_LVL_ODT, S_LVL_LOAD, S_VOLT
  } dimp_state_t;
  dimp_state_t state_reg;
  logic [31:0] cnt_reg;
  logic [1:0] idx_reg;
  logic [7:0] div_reg;
  logic ck_reg;
  logic rise_w;
  logic dq_s;
  logic [15:0] word_w;
  logic [2:0] bank_w;
  assign rise_w = (div_reg == 8'(LINK_DIV - 1)) && !ck_reg;
  dimp_sync #(.W(1)) u_sync (.i_mclk(i_mclk), .i_rst(i_rst), .i_d(lnk.dq_o), .o_q(dq_s));
  ////////////////////////////////////////////////////////////////
  // link clock divider; it runs freely so the device always sees a valid clock
  // commands change with the rising link edge; the device takes pins and clock through
  // one synchroniser, so both arrive in the same cycle and stay coherent
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      div_reg <= 8'h00;
      ck_reg <= 1'b0;
    end else if (div_reg == 8'(LINK_DIV - 1)) begin
      div_reg <= 8'h00;
      ck_reg <= ~ck_reg;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end
  assign lnk.ck = ck_reg;
  // load order two, three, one, zero; each word carries every field
  always_comb begin
    case (idx_reg)
      2'h0: begin word_w = {MR_TWO, i_mode_two[12:0]}; bank_w = MR_TWO; end // [R12] [R17]
      2'h1: begin word_w = {MR_THREE, i_mode_three[12:0]}; bank_w = MR_THREE; end
      2'h2: begin word_w = {MR_ONE, i_mode_one[12:0]}; bank_w = MR_ONE; end
      default: begin
        word_w = {MR_ZERO, i_mode_zero[12:0]};
        word_w[LOOP_RST_BIT] = 1'b1; // [R13]
        bank_w = MR_ZERO;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////
  // sequencer: counts mclk for long waits, link rising edges for command gaps
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_reg <= S_IDLE;
      cnt_reg <= 32'h0000_0000;
      idx_reg <= 2'h0;
      lnk.rst_n <= 1'b0;
      lnk.cke <= 1'b0;
      lnk.termination_control <= 1'b0;
      lnk.cmd <= DIMP_CMD_NOP;
      lnk.bank <= 3'h0;
      lnk.addr <= 16'h0000;
      lnk.dqs_o <= 1'b0;
      lnk.dqs_oe <= 1'b0;
      o_ready <= 1'b0;
    end else begin
      if (rise_w) lnk.cmd <= DIMP_CMD_NOP; // one command per link cycle
      case (state_reg)
        S_IDLE: if (i_start) begin
          lnk.rst_n <= 1'b0;
          lnk.cke <= 1'b0;
          o_ready <= 1'b0;
          cnt_reg <= 32'h0000_0000;
          state_reg <= S_RST_HOLD;
        end
        S_RST_HOLD: begin
          if (!i_power_ok) cnt_reg <= 32'h0000_0000; // [R06]
          else if (cnt_reg >= 32'(RESET_HOLD - 1)) begin
            cnt_reg <= 32'h0000_0000;
            state_reg <= S_CKE_SETUP;
          end else cnt_reg <= cnt_reg + 32'h1;
        end
        S_CKE_SETUP: begin // clock enable has been low since reset
          if (cnt_reg >= 32'(CKE_SETUP_CYC)) begin // [R24]
            lnk.rst_n <= 1'b1; // [R08]
            cnt_reg <= 32'h0000_0000;
            state_reg <= S_CKE_WAIT;
          end else cnt_reg <= cnt_reg + 32'h1;
        end
        S_CKE_WAIT: begin
          lnk.termination_control <= 1'b0; // [R10]
          if (cnt_reg >= 32'(CKE_WAIT - 1)) begin // [R09]
            cnt_reg <= 32'h0000_0000;
            state_reg <= S_PRE_CKE;
          end else cnt_reg <= cnt_reg + 32'h1;
        end
        S_PRE_CKE: if (rise_w) begin
          if (cnt_reg >= 32'(MIN_PRE_CKE_LINK)) begin // [R10]
            lnk.cke <= 1'b1; // [R11]
            cnt_reg <= 32'h0000_0000;
            state_reg <= S_XPR;
          end else cnt_reg <= cnt_reg + 32'h1;
        end
        S_XPR: if (rise_w) begin
          if (cnt_reg >= 32'(RESET_EXIT_LINK)) begin
            idx_reg <= 2'h0;
            state_reg <= S_LOAD;
          end else cnt_reg <= cnt_reg + 32'h1;
        end
        S_LOAD: if (rise_w && i_banks_idle) begin // [R18]
          lnk.cmd <= DIMP_CMD_LOAD;
          lnk.bank <= bank_w;
          lnk.addr <= word_w;
          lnk.termination_control <= 1'b0; // [R22]
          cnt_reg <= 32'h0000_0000;
          state_reg <= S_LOAD_GAP;
        end
        S_LOAD_GAP: if (rise_w) begin
          cnt_reg <= cnt_reg + 32'h1;
          if (idx_reg != 2'h3 && cnt_reg >= 32'(MODE_TO_MODE_LINK - 1)) begin // [R19]
            idx_reg <= idx_reg + 2'h1;
            state_reg <= S_LOAD;
          end else if (idx_reg == 2'h3 && cnt_reg >= 32'(MODE_UPDATE_LINK - 1)) begin // [R20]
            lnk.cmd <= DIMP_CMD_CALIB; // [R14]
            cnt_reg <= 32'h0000_0000;
            state_reg <= S_CALIB;
          end
        end
        S_CALIB: if (rise_w) begin // lock already overlaps calibration from the zero load
          if (cnt_reg >= 32'(LOOP_LOCK_LINK > CALIB_INIT_LINK ? LOOP_LOCK_LINK
                                                              : CALIB_INIT_LINK)) begin
            o_ready <= 1'b1; // [R14]
            state_reg <= S_DONE;
          end else cnt_reg <= cnt_reg + 32'h1;
        end
        S_DONE: begin
          lnk.termination_control <= !i_volt_change; // termination on in normal use, off for a switch [R15]
          if (i_volt_change) begin // [R15]
            o_ready <= 1'b0;
            state_reg <= S_VOLT;
          end else if (i_lvl_exit) begin
            lnk.dqs_oe <= 1'b1; // strobe parked low until the feedback is captured
            cnt_reg <= 32'h0000_0000;
            state_reg <= S_LVL_WAIT;
          end
        end
        S_VOLT: if (!i_volt_change && i_banks_idle) begin // nop only while switching
          idx_reg <= 2'h3; // relock loop then recalibrate
          state_reg <= S_LOAD;
        end
        S_LVL_WAIT: if (rise_w) begin // capture feedback before releasing strobe
          cnt_reg <= cnt_reg + 32'h1;
          // drop termination late, so its off latency ends only after the strobe is released
          if (cnt_reg >= 32'(MODE_UPDATE_LINK - LAT_LO + 1)) lnk.termination_control <= 1'b0; // [R03]
          if (cnt_reg >= 32'(MODE_UPDATE_LINK)) begin // [R01]
            lnk.dqs_oe <= 1'b0;
            cnt_reg <= 32'h0000_0000;
            state_reg <= S_LVL_ODT;
          end
        end
        S_LVL_ODT: if (rise_w) begin
          cnt_reg <= cnt_reg + 32'h1;
          if (cnt_reg >= 32'(LAT_HI)) state_reg <= S_LVL_LOAD; // [R04]
        end
        S_LVL_LOAD: if (rise_w && i_banks_idle) begin
          lnk.cmd <= DIMP_CMD_LOAD; // [R04]
          lnk.bank <= MR_ONE;
          lnk.addr <= {MR_ONE, i_mode_one[12:LEVEL_BIT+1], 1'b0, i_mode_one[LEVEL_BIT-1:0]}; // [R05]
          cnt_reg <= 32'h0000_0000;
          state_reg <= S_CALIB; // waits past update and loop-off exit delays
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
  // clock enable never drops once raised, so power-down spacing is always kept
  assign o_busy = (state_reg != S_DONE) && (state_reg != S_IDLE); // [R21] [R23]
  // synchronised leveling feedback; one more flop keeps the output registered
  always_ff @(posedge i_mclk) begin
    if (i_rst) o_lvl_sample <= 1'b0;
    else o_lvl_sample <= dq_s;
  end
endmodule // dimp_ctrl

// File: dimp_pkg.sv
// Overview of operation
// [R01] release strobe after leveling delay plus capture
// [R02] data undefined until mode update after exit
// [R03] termination low at exit until next phase
// [R04] exit load after termination off, then delays
// [R05] exit load clears leveling bit seven
// [R06] reset held at least 200 us
// [R07] termination off until clock enable registered
// [R08] clock enable low 10 ns before release
// [R09] wait 500 us less one clock
// [R10] five clocks, termination low, nop only
// [R11] clock enable stays high through init
// [R12] load order two, three, one, zero
// [R13] register zero resets loop, 512 cycles
// [R14] long calibration last, then ready
// [R15] voltage change: nop, then relock, calibrate
// [R16] registers persist; loop reset bit self-clears
// [R17] every load supplies all fields
// [R18] load only when banks idle
// [R19] mode-to-mode delay between loads
// [R20] only nop until mode update delay
// [R21] clock enable high until powerdown delay
// [R22] termination low until mode update met
// [R23] latency change waits loop-off exit delay
// [R24] all delays rounded up to cycles
package dimp_pkg;
  localparam int CLK_PERIOD_PS = 25000;
  localparam int RESET_HOLD_US = 200;
  localparam int CKE_WAIT_US = 500;
  localparam int CKE_SETUP_NS = 10;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CKE_WAIT_CYC = (CKE_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS - 1;
  localparam int CKE_SETUP_CYC = (CKE_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // delays below are counted in link clock cycles
  localparam int MIN_PRE_CKE_LINK = 5;
  localparam int MODE_TO_MODE_LINK = 4;
  localparam int MODE_UPDATE_LINK = 12;
  localparam int RESET_EXIT_LINK = 5;
  localparam int LOOP_LOCK_LINK = 512;
  localparam int CALIB_INIT_LINK = 512;
  localparam int LOOP_OFF_EXIT_LINK = 10;
  localparam int LINK_DIV = 4;
  localparam int LEVEL_BIT = 7;
  localparam int LOOP_RST_BIT = 8;
  localparam int LAT_LO = 4;
  localparam int LAT_HI = 6;
  localparam logic [2:0] MR_ZERO = 3'h0;
  localparam logic [2:0] MR_ONE = 3'h1;
  localparam logic [2:0] MR_TWO = 3'h2;
  localparam logic [2:0] MR_THREE = 3'h3;
  typedef enum logic [2:0] {
    DIMP_CMD_NOP, DIMP_CMD_LOAD, DIMP_CMD_CALIB, DIMP_CMD_OTHER
  } dimp_cmd_t;
endpackage

// File: dimp_if.sv
`timescale 1ns/1ps
// command link between controller and memory device
interface dimp_if;
  logic ck;
  logic rst_n;
  logic cke;
  logic termination_control;
  dimp_pkg::dimp_cmd_t cmd;
  logic [2:0] bank;
  logic [15:0] addr;
  logic dqs_o;
  logic dqs_oe;
  logic dq_o;
  logic dq_oe;
  modport ctrl (output ck, rst_n, cke, termination_control, cmd, bank, addr, dqs_o, dqs_oe, input dq_o, dq_oe);
  modport mem (input ck, rst_n, cke, termination_control, cmd, bank, addr, dqs_o, dqs_oe, output dq_o, dq_oe);
endinterface

// File: dimp_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for pin inputs
module dimp_sync #(
  parameter int W = 1
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  if (W < 1) begin : g_bad_width
    $error("synchroniser width must be positive");
  end
  logic [W-1:0] meta_reg;
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      meta_reg <= '0;
      o_q <= '0;
    end else begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end
endmodule // dimp_sync

// File: dimp_mem.sv
`timescale 1ns/1ps
// memory device end: registers commands on link clock rising edges
module dimp_mem
  import dimp_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  dimp_if.mem lnk,
  output logic o_term_on,
  output logic o_ready,
  output logic o_feat_avail,
  output logic [15:0] o_mode_zero,
  output logic [15:0] o_mode_one,
  output logic [15:0] o_mode_two,
  output logic [15:0] o_mode_three
);
  import dimp_pkg::*;
  logic [25:0] raw;
  logic [25:0] s;
  assign raw = {lnk.ck, lnk.rst_n, lnk.cke, lnk.termination_control, lnk.cmd, lnk.bank, lnk.addr};
  dimp_sync #(.W(26)) u_sync (.i_mclk(i_mclk), .i_rst(i_rst), .i_d(raw), .o_q(s));
  logic ck_d_reg;
  logic edge_w;
  logic cke_seen_reg;
  logic [15:0] upd_cnt_reg;
  logic [15:0] lock_cnt_reg;
  logic lvl_reg;
  dimp_cmd_t cmd_w;
  // synchronised pins: ck 25, rst_n 24, cke 23, odt 22, cmd 21:19, bank 18:16, addr 15:0
  assign cmd_w = dimp_cmd_t'(s[21:19]);
  assign edge_w = s[25] & ~ck_d_reg;
  ////////////////////////////////////////////////////////////////
  // edge finder on the sampled link clock
  always_ff @(posedge i_mclk) begin
    if (i_rst) ck_d_reg <= 1'b0;
    else ck_d_reg <= s[25];
  end
  // termination stays off until clock enable is registered high
  always_ff @(posedge i_mclk) begin
    if (i_rst || !s[24]) cke_seen_reg <= 1'b0; // [R07]
    else if (edge_w && s[23]) cke_seen_reg <= 1'b1; // [R07]
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) o_term_on <= 1'b0;
    else o_term_on <= cke_seen_reg & s[22] & s[24]; // [R07]
  end
  ////////////////////////////////////////////////////////////////
  // mode registers: hold until reload or reset; loop reset self-clears
  always_ff @(posedge i_mclk) begin
    if (i_rst || !s[24]) begin
      o_mode_zero <= 16'h0000; // [R16]
      o_mode_one <= 16'h0000;
      o_mode_two <= 16'h0000;
      o_mode_three <= 16'h0000;
    end else if (edge_w && cmd_w == DIMP_CMD_LOAD) begin
      case (s[18:16]) // bank bits pick the register
        MR_ZERO: o_mode_zero <= s[15:0];
        MR_ONE: o_mode_one <= s[15:0];
        MR_TWO: o_mode_two <= s[15:0];
        MR_THREE: o_mode_three <= s[15:0];
        default: ;
      endcase
    end else if (edge_w) begin
      o_mode_zero[LOOP_RST_BIT] <= 1'b0; // [R16]
    end
  end
  ////////////////////////////////////////////////////////////////
  // update and lock timers; features unavailable until update done
  always_ff @(posedge i_mclk) begin
    if (i_rst || !s[24]) begin
      upd_cnt_reg <= 16'h0000;
      lock_cnt_reg <= 16'h0000;
    end else if (edge_w) begin
      if (cmd_w == DIMP_CMD_LOAD) upd_cnt_reg <= 16'(MODE_UPDATE_LINK); // [R20]
      else if (upd_cnt_reg != 16'h0000) upd_cnt_reg <= upd_cnt_reg - 16'h0001;
      if (cmd_w == DIMP_CMD_LOAD && s[18:16] == MR_ZERO && s[LOOP_RST_BIT])
        lock_cnt_reg <= 16'(LOOP_LOCK_LINK);
      else if (lock_cnt_reg != 16'h0000) lock_cnt_reg <= lock_cnt_reg - 16'h0001;
    end
  end
  assign o_feat_avail = (upd_cnt_reg == 16'h0000); // [R20]
  assign o_ready = o_feat_avail && (lock_cnt_reg == 16'h0000) && s[23];
  ////////////////////////////////////////////////////////////////
  // leveling feedback; data undefined (driven low here) until update after exit
  always_ff @(posedge i_mclk) begin
    if (i_rst) lvl_reg <= 1'b0;
    else lvl_reg <= o_mode_one[LEVEL_BIT] | ~o_feat_avail; // [R02]
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      lnk.dq_o <= 1'b0;
      lnk.dq_oe <= 1'b0;
    end else begin
      lnk.dq_o <= o_mode_one[LEVEL_BIT] & s[25];
      lnk.dq_oe <= lvl_reg;
    end
  end
endmodule // dimp_mem

// File: dimp_chk_sva.sv
`timescale 1ns/1ps
// link-level checks on the command pins between controller and device
module dimp_chk
  import dimp_pkg::*;
#(
  parameter int RESET_HOLD = RESET_HOLD_CYC,
  parameter int CKE_WAIT = CKE_WAIT_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic ck,
  input wire logic rst_n,
  input wire logic cke,
  input wire logic termination_control,
  input wire dimp_pkg::dimp_cmd_t cmd,
  input wire logic [2:0] bank,
  input wire logic [15:0] addr
);
  import dimp_pkg::*;
  localparam int MRD_MCLK = MODE_TO_MODE_LINK * 2 * LINK_DIV;
  localparam int MOD_MCLK = MODE_UPDATE_LINK * 2 * LINK_DIV;
  logic [15:0] low_cnt;
  logic [15:0] high_cnt;
  logic [15:0] gap_cnt;
  logic prev_load;
  logic load_start;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  //////////////////////////////////////////////////////////////////////////////
  // a load is counted once, at the first cycle it shows on the pins
  assign load_start = (cmd == DIMP_CMD_LOAD) && !prev_load;
  always_ff @(posedge i_mclk) begin
    prev_load <= !i_rst && (cmd == DIMP_CMD_LOAD);
  end
  // cycles the reset pin has been low; saturates so long holds never wrap
  always_ff @(posedge i_mclk) begin
    if (i_rst || rst_n) begin
      low_cnt <= 16'h0;
    end else if (low_cnt != 16'hFFFF) begin
      low_cnt <= low_cnt + 16'h1;
    end
  end
  // cycles since reset release with clock enable still low
  always_ff @(posedge i_mclk) begin
    if (i_rst || !rst_n) begin
      high_cnt <= 16'h0;
    end else if (!cke && high_cnt != 16'hFFFF) begin
      high_cnt <= high_cnt + 16'h1;
    end
  end
  // distance from the last load; starts saturated so the first load is free
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      gap_cnt <= 16'hFFFF;
    end else if (load_start) begin
      gap_cnt <= 16'h1;
    end else if (gap_cnt != 16'hFFFF) begin
      gap_cnt <= gap_cnt + 16'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  rst_hold_a: assert property ($rose(rst_n) |-> low_cnt >= RESET_HOLD)
    else $error("reset pin released too early");
  cke_setup_a: assert property ($rose(rst_n) |-> !cke && $past(cke) == 1'b0)
    else $error("clock enable not low before reset release");
  cke_wait_a: assert property ($rose(cke) |-> high_cnt >= CKE_WAIT)
    else $error("clock enable raised too soon");
  cke_hold_a: assert property (cke |=> cke)
    else $error("clock enable dropped");
  odt_precke_a: assert property ($rose(cke) |-> !termination_control && $past(termination_control) == 1'b0)
    else $error("termination not low ahead of clock enable");
  nop_precke_a: assert property (!cke |-> cmd == DIMP_CMD_NOP)
    else $error("command issued with clock enable low");
  load_gap_a: assert property (load_start |-> gap_cnt >= MRD_MCLK)
    else $error("loads too close together");
  update_wait_a: assert property ((cmd == DIMP_CMD_CALIB || cmd == DIMP_CMD_OTHER)
    |-> gap_cnt >= MOD_MCLK)
    else $error("command inside mode update delay");
  odt_update_a: assert property ((cmd == DIMP_CMD_LOAD || gap_cnt < MOD_MCLK) |-> !termination_control)
    else $error("termination high near a load");
  loop_reset_a: assert property (load_start && bank == MR_ZERO |-> addr[LOOP_RST_BIT])
    else $error("register zero load without loop reset");
  load_stand_a: assert property (load_start |=> (cmd == DIMP_CMD_LOAD && $stable(bank)
    && $stable(addr))[*7])
    else $error("load did not stand a full link cycle");
  cover property (load_start && bank == MR_TWO);
  cover property ($rose(cke));
  cover property (cmd == DIMP_CMD_CALIB);
  cover property ($rose(ck));
endmodule // dimp_chk

// File: dram_init_and_mode_programming_tb.sv
`timescale 1ns/1ps
// end-to-end bench: controller and device joined by the link interface
module dram_init_and_mode_programming_tb;
  import dimp_pkg::*;
  logic mclk, rst, start, power_ok, lvl_exit, volt_change, banks_idle;
  logic [15:0] m0, m1, m2, m3, mz, mo, mt, mh;
  logic busy, ctrl_ready, lvl_sample, term_on, mem_ready, feat_avail;
  logic [18:0] exp_q[$];
  dimp_cmd_t prev_cmd;
  int failures, cmp_count, cyc_n, calib_t;
  integer seed;
  logic lvl_a;
  dimp_if lnk();
  always #12.5 mclk = ~mclk;
  //////////////////////////////////////////////////////////////////////////////
  // short reset and wait counts keep the run well under the cycle budget
  dimp_ctrl #(.RESET_HOLD(20), .CKE_WAIT(30)) u_dimp_ctrl (.i_mclk(mclk), .i_rst(rst),
    .lnk(lnk), .i_start(start), .i_power_ok(power_ok), .i_mode_zero(m0), .i_mode_one(m1),
    .i_mode_two(m2), .i_mode_three(m3), .i_lvl_exit(lvl_exit), .i_volt_change(volt_change),
    .i_banks_idle(banks_idle), .o_busy(busy), .o_ready(ctrl_ready), .o_lvl_sample(lvl_sample));
  dimp_mem u_dimp_mem (.i_mclk(mclk), .i_rst(rst), .lnk(lnk), .o_term_on(term_on),
    .o_ready(mem_ready), .o_feat_avail(feat_avail), .o_mode_zero(mz), .o_mode_one(mo),
    .o_mode_two(mt), .o_mode_three(mh));
  dimp_chk #(.RESET_HOLD(20), .CKE_WAIT(30)) u_dimp_chk (.i_mclk(mclk), .i_rst(rst),
    .ck(lnk.ck), .rst_n(lnk.rst_n), .cke(lnk.cke), .termination_control(lnk.termination_control), .cmd(lnk.cmd),
    .bank(lnk.bank), .addr(lnk.addr));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (failures == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // inputs always move one nanosecond after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic note(input dimp_cmd_t c, input logic [2:0] b, input logic [15:0] a);
    exp_q.push_back((c == DIMP_CMD_CALIB) ? {c, 16'h0} : {c, b, a[12:0]});
  endtask
  // bounded wait until every noted command went out and the controller settled
  task automatic wait_done(input int limit);
    int n;
    n = 0;
    while (!(exp_q.size() == 0 && busy === 1'b0 && ctrl_ready === 1'b1) && n < limit) begin
      cyc(1);
      n++;
    end
    if (n >= limit) begin
      failures++;
      $display("ERROR %0t: wait ran out", $time);
      conclude();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // every new non-idle command on the link is matched against the oldest note
  always @(posedge mclk) begin
    cyc_n++;
    if (rst) begin
      prev_cmd = DIMP_CMD_NOP;
    end else if (lnk.cmd !== prev_cmd) begin
      prev_cmd = lnk.cmd;
      if (lnk.cmd == DIMP_CMD_CALIB) begin
        calib_t = cyc_n;
      end
      if (lnk.cmd != DIMP_CMD_NOP && exp_q.size() == 0) begin
        check({lnk.cmd, 16'hFFFF}, 19'h0);
      end else if (lnk.cmd != DIMP_CMD_NOP) begin
        check((lnk.cmd == DIMP_CMD_CALIB) ? {lnk.cmd, 16'h0}
          : {lnk.cmd, lnk.bank, lnk.addr[12:0]}, exp_q.pop_front());
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 20;
    {mclk, start, power_ok, lvl_exit, volt_change} = 5'h0;
    {rst, banks_idle} = 2'h3;
    {failures, cmp_count, cyc_n, calib_t} = 0;
    m0 = 16'($random(seed));
    m1 = 16'($random(seed)) | 16'h0080;
    m2 = 16'($random(seed));
    m3 = 16'($random(seed));
    cyc(5);
    rst = 0;
    // power-up with supplies late: reset pin and termination must stay off
    cyc(1);
    start = 1;
    cyc(1);
    start = 0;
    cyc(60);
    check({18'h0, lnk.rst_n}, 19'h0);
    check({18'h0, term_on}, 19'h0);
    note(DIMP_CMD_LOAD, MR_TWO, m2);
    note(DIMP_CMD_LOAD, MR_THREE, m3);
    note(DIMP_CMD_LOAD, MR_ONE, m1);
    note(DIMP_CMD_LOAD, MR_ZERO, m0 | 16'h0100);
    note(DIMP_CMD_CALIB, 3'h0, 16'h0);
    power_ok = 1;
    wait_done(20000);
    check({18'h0, cyc_n - calib_t >= CALIB_INIT_LINK * 2 * LINK_DIV - 1}, 19'h1);
    check({18'h0, mem_ready}, 19'h1);
    check({6'h0, mt[12:0]}, {6'h0, m2[12:0]});
    check({6'h0, mz[12:0]}, {6'h0, m0[12:0] & 13'h1EFF});
    check({6'h0, mo[12:0]}, {6'h0, m1[12:0]});
    check({6'h0, mh[12:0]}, {6'h0, m3[12:0]});
    // leveling stays on after init: the feedback follows the link clock
    cyc(8);
    check({18'h0, term_on}, 19'h1);
    lvl_a = lvl_sample;
    cyc(4);
    check({18'h0, lvl_sample ^ lvl_a}, 19'h1);
    // leveling exit while banks are busy: the load must hold off
    banks_idle = 0;
    note(DIMP_CMD_LOAD, MR_ONE, m1 & 16'hFF7F);
    lvl_exit = 1;
    cyc(1);
    lvl_exit = 0;
    check({18'h0, lnk.dqs_oe}, 19'h1);
    cyc(300);
    check({18'h0, exp_q.size() == 1}, 19'h1);
    check({18'h0, lnk.dqs_oe}, 19'h0);
    banks_idle = 1;
    wait_done(5000);
    check({18'h0, mo[LEVEL_BIT]}, 19'h0);
    check({18'h0, feat_avail}, 19'h1);
    check({18'h0, lvl_sample}, 19'h0);
    // supply switch: idle link, then loop reset and calibration again
    volt_change = 1;
    cyc(100);
    check({18'h0, term_on}, 19'h0);
    note(DIMP_CMD_LOAD, MR_ZERO, m0 | 16'h0100);
    note(DIMP_CMD_CALIB, 3'h0, 16'h0);
    volt_change = 0;
    wait_done(8000);
    check({18'h0, mem_ready}, 19'h1);
    // mid-run reset wipes the device images
    rst = 1;
    cyc(5);
    rst = 0;
    cyc(2);
    check({3'h0, mt}, 19'h0);
    conclude();
  end
endmodule // dram_init_and_mode_programming_tb
